// >>> hw/swm_defs.svh
// Constants of the switch monitor serial slave: bit positions, codes, reset values
`ifndef SWM_DEFS_SVH
`define SWM_DEFS_SVH

// Word and input counts
`define SWM_WORD_BITS     24
`define SWM_NUM_DUAL      8
`define SWM_NUM_GND       14
`define SWM_NUM_SW        22
`define SWM_NUM_PINS      28
`define SWM_FIFO_DEPTH    32

// Comparator threshold of every switch input, millivolts (analog, for reference)
`define SWM_THRESHOLD_MV  4000

// Positions in the synchronised pin vector
`define SWM_PIN_CS        27
`define SWM_PIN_SCLK      26
`define SWM_PIN_SI        25
`define SWM_PIN_ALERT     24
`define SWM_PIN_WAKE      23
`define SWM_PIN_VDD       22

// Status word layout
`define SWM_BIT_THERMAL   23
`define SWM_BIT_ALERT     22
`define SWM_GND_LSB       8

// Command word layout and command codes
`define SWM_CMD_MSB       23
`define SWM_CMD_LSB       16
`define SWM_CMD_SETTINGS  8'h01
`define SWM_CMD_ALERTEN   8'h02
`define SWM_CMD_SLEEP     8'h03

// Reset values: all dual inputs to battery, all inputs alert-enabled; then the last bit index of a word
`define SWM_POL_RESET     8'hff
`define SWM_ENA_RESET     22'h3f_ffff
`define SWM_BITCNT_LAST   5'h17

`endif

// >>> hw/swm_pkg.sv
// Types shared by the switch monitor serial slave
package swm_pkg;
    typedef enum logic {
        SWM_NORMAL,
        SWM_SLEEP
    } swm_mode_t;

    typedef struct packed {
        logic [27:0] syncA;
        logic [27:0] syncB;
        logic [27:0] prev;
        swm_mode_t   mode;
        logic [23:0] shiftWord;
        logic [4:0]  bitCnt;
        logic        gotBits;
        logic        soOut;
        logic        soOeN;
        logic        alertOeN;
        logic        wakeOeN;
        logic        changedDuringCs;
        logic [21:0] refState;
        logic [7:0]  polarity;
        logic [21:0] alertEnable;
        logic        pendValid;
        logic [23:0] pendWord;
        logic        cmdDropped;
    } swm_state_t;
endpackage

// >>> hw/swm_serial_slave.sv
// Switch monitor serial slave with wake/alert control and its command FIFO
// Notes on behaviour
// RULE1: Select fall enables output driver, captures alert state and switch states.
// RULE2: Select rise returns the serial output to high impedance.
// RULE3: Select rise releases alert unless a switch changed while selected.
// RULE4: Received command takes effect only at the select rise.
// RULE5: Master changes select only with clock low and sends whole words.
// RULE6: Select fall wakes from Sleep with logic supply; that data may be stale.
// RULE7: Serial input sampled on each falling serial clock edge.
// RULE8: Next status bit driven at each rising edge, read at the falling edge.
// RULE9: Master should hold serial clock low while idle and deselected.
// RULE10: With select high, clock and input ignored and output tri-stated.
// RULE11: A command word is 24 bits; a received one applies as one.
// RULE12: Open switch reads as zero, closed switch reads as one.
// RULE13: First rising edge presents status bit 23, then lower bits follow.
// RULE14: Input and output words shift together, most significant bit first.
// RULE15: In Normal, an enabled switch change pulls the open-drain alert low.
// RULE16: Alert flag in the response shows this device's own latched alert.
// RULE17: In Sleep, alert-line fall with wake high and supply present wakes.
// RULE18: Wake pin driven low in Normal and released in Sleep.
// RULE19: In Sleep, wake-pin fall wakes; alert must be high if supply present.
// RULE20: Select or alert wake-up only when the logic supply is present.
// RULE21: Dual input for battery is closed above threshold; inverted for ground.
// RULE22: Ground-only input is closed below threshold.
// RULE23: Every response carries switch states, alert flag and thermal flag.
// RULE24: Two chained devices need 48 clocks per transfer.
// RULE25: Change found by comparing each enabled input with its last captured level.
`timescale 1ns/1ps
`include "swm_defs.svh"

module swm_cmd_fifo #(
    parameter int WIDTH = `SWM_WORD_BITS,
    parameter int DEPTH = `SWM_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [AW-1:0]    wrPtr;
        logic [AW-1:0]    rdPtr;
        logic [CW-1:0]    count;
        logic             outValid;
        logic [WIDTH-1:0] outData;
    } swm_fifo_state_t;

    swm_fifo_state_t  s_reg;
    swm_fifo_state_t  s_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // Pointer wrap uses power-of-two arithmetic
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_check
        $error("swm_cmd_fifo: DEPTH must be a power of two, at least 2");
    end

    assign inReady  = (s_reg.count != CW'(DEPTH));
    assign outValid = s_reg.outValid;
    assign outData  = s_reg.outData;
    assign push     = inValid && inReady;
    // Output stage refills when empty or when its word is taken
    assign pop      = (s_reg.count != '0) && (!s_reg.outValid || outReady);

    // Pointers, fill count and registered output word
    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.wrPtr = s_reg.wrPtr + AW'(1);
        end
        if (pop) begin
            s_next.rdPtr    = s_reg.rdPtr + AW'(1);
            s_next.outData  = mem[s_reg.rdPtr];
            s_next.outValid = 1'b1;
        end else if (outReady) begin
            s_next.outValid = 1'b0;
        end
        s_next.count = s_reg.count + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Storage array, written only on accepted words
    always_ff @(posedge clk) begin
        if (push) begin
            mem[s_reg.wrPtr] <= inData;
        end
    end
endmodule

module swm_serial_slave #(
    parameter int FIFO_DEPTH = `SWM_FIFO_DEPTH
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        csN,
    input  wire logic        sclk,
    input  wire logic        si,
    output logic             soOut,
    output logic             soOeN,
    input  wire logic        alertIn,
    output logic             alertOut,
    output logic             alertOeN,
    input  wire logic        wakeIn,
    output logic             wakeOut,
    output logic             wakeOeN,
    input  wire logic        vddPresent,
    input  wire logic        thermalFlag,
    input  wire logic [7:0]  dual_polarity_inputs,
    input  wire logic [13:0] ground_contact_inputs,
    output logic             cmdValid,
    input  wire logic        cmdReady,
    output logic [23:0]      cmdWord,
    output logic             cmdDropped
);
    swm_pkg::swm_state_t s_reg;
    swm_pkg::swm_state_t s_next;
    logic [27:0]         pins;
    logic                csHigh;
    logic                csFall;
    logic                csRise;
    logic                sclkRise;
    logic                sclkFall;
    logic                alertFall;
    logic                wakeFall;
    logic                vddOk;
    logic                isSleep;
    logic [21:0]         closedNow;
    logic [21:0]         change;
    logic                anyChange;
    logic                wordDone;
    logic [23:0]         statusWord;
    logic                fifoInReady;
    logic                fifoOutValid;
    logic [23:0]         fifoOutData;

    // All pins except thermalFlag and cmdReady pass two flip-flops before any logic reads them
    assign pins = {csN, sclk, si, alertIn, wakeIn, vddPresent,
                   ground_contact_inputs, dual_polarity_inputs};

    // Edges are taken between the second stage and a third copy
    assign csHigh    = s_reg.syncB[`SWM_PIN_CS];
    assign csFall    = s_reg.prev[`SWM_PIN_CS] && !csHigh;
    assign csRise    = !s_reg.prev[`SWM_PIN_CS] && csHigh;
    assign sclkRise  = !csHigh && !csFall &&
                       !s_reg.prev[`SWM_PIN_SCLK] && s_reg.syncB[`SWM_PIN_SCLK]; // [RULE10]
    assign sclkFall  = !csHigh && !csFall &&
                       s_reg.prev[`SWM_PIN_SCLK] && !s_reg.syncB[`SWM_PIN_SCLK]; // [RULE10]
    assign alertFall = s_reg.prev[`SWM_PIN_ALERT] && !s_reg.syncB[`SWM_PIN_ALERT];
    assign wakeFall  = s_reg.prev[`SWM_PIN_WAKE] && !s_reg.syncB[`SWM_PIN_WAKE];
    assign vddOk     = s_reg.syncB[`SWM_PIN_VDD];
    assign isSleep   = (s_reg.mode == swm_pkg::SWM_SLEEP);

    // Comparator level is high above threshold; closed means one
    assign closedNow[7:0]  = ~(s_reg.syncB[7:0] ^ s_reg.polarity); // [RULE21] [RULE12]
    assign closedNow[21:8] = ~s_reg.syncB[21:8];                   // [RULE22] [RULE12]
    assign change    = (closedNow ^ s_reg.refState) & s_reg.alertEnable; // [RULE25]
    assign anyChange = |change;
    // Whole words only: a partial count leaves bitCnt away from zero
    assign wordDone  = s_reg.gotBits && (s_reg.bitCnt == 5'h00); // [RULE11] [RULE24]

    // Response always carries thermal flag, own alert state and switches
    assign statusWord = {thermalFlag, !s_reg.alertOeN, closedNow}; // [RULE23] [RULE16]

    // Next-state logic of the whole slave
    always_comb begin
        s_next = s_reg;
        s_next.syncA      = pins;
        s_next.syncB      = s_reg.syncA;
        s_next.prev       = s_reg.syncB;
        s_next.cmdDropped = 1'b0;

        // Enabled change: alert in either mode, wake-up in Sleep
        if (anyChange) begin
            s_next.refState = s_reg.refState ^ change;                 // [RULE25]
            s_next.alertOeN = 1'b0;                                    // [RULE15]
            s_next.mode     = swm_pkg::SWM_NORMAL;
            if (!csHigh) begin
                s_next.changedDuringCs = 1'b1;
            end
        end

        // Wake-up sources while asleep
        if (isSleep) begin
            if (csFall && vddOk) begin
                s_next.mode = swm_pkg::SWM_NORMAL;                     // [RULE6] [RULE20]
            end
            if (alertFall && s_reg.syncB[`SWM_PIN_WAKE] && vddOk) begin
                s_next.mode = swm_pkg::SWM_NORMAL;                     // [RULE17] [RULE20]
            end
            if (wakeFall && (!vddOk || s_reg.syncB[`SWM_PIN_ALERT])) begin
                s_next.mode = swm_pkg::SWM_NORMAL;                     // [RULE19]
            end
        end

        // Pending command word drains into the FIFO
        if (s_reg.pendValid && fifoInReady) begin
            s_next.pendValid = 1'b0;
        end

        // Select fall: drive output, snapshot status, restart the count
        if (csFall) begin
            s_next.soOeN           = 1'b0;                             // [RULE1]
            s_next.shiftWord       = statusWord;                       // [RULE1]
            s_next.soOut           = statusWord[23];
            s_next.refState        = closedNow;
            s_next.bitCnt          = 5'h00;
            s_next.gotBits         = 1'b0;
            // Set wins: a change in the fall cycle still keeps the alert
            s_next.changedDuringCs = anyChange;                        // [RULE3]
        end

        // One shift register serves both directions, MSB first
        if (sclkRise) begin
            s_next.soOut = s_reg.shiftWord[23];                        // [RULE8] [RULE13]
        end
        if (sclkFall) begin
            s_next.shiftWord = {s_reg.shiftWord[22:0],
                                s_reg.syncB[`SWM_PIN_SI]};             // [RULE7] [RULE14]
            if (s_reg.bitCnt == `SWM_BITCNT_LAST) begin
                s_next.bitCnt  = 5'h00;
                s_next.gotBits = 1'b1;
            end else begin
                s_next.bitCnt  = s_reg.bitCnt + 5'h01;
            end
        end

        // Select rise: release output, clear alert, apply the command
        if (csRise) begin
            s_next.soOeN    = 1'b1;                                    // [RULE2]
            // Set wins: a change in this very cycle keeps the alert low
            s_next.alertOeN = !(s_reg.changedDuringCs || (anyChange)); // [RULE3]
            if (wordDone && !isSleep && vddOk) begin                   // [RULE4]
                unique case (s_reg.shiftWord[`SWM_CMD_MSB:`SWM_CMD_LSB])
                    `SWM_CMD_SETTINGS: s_next.polarity    = s_reg.shiftWord[7:0];
                    `SWM_CMD_ALERTEN:  s_next.alertEnable = s_reg.shiftWord[21:0];
                    `SWM_CMD_SLEEP:    s_next.mode        = swm_pkg::SWM_SLEEP;
                    default:           s_next.polarity    = s_reg.polarity;
                endcase
                // Slot still occupied and FIFO full: the word is not queued
                if (!s_reg.pendValid || fifoInReady) begin
                    s_next.pendValid = 1'b1;
                    s_next.pendWord  = s_reg.shiftWord;
                end else begin
                    s_next.cmdDropped = 1'b1;
                end
            end
        end

        // Wake pin follows the mode; it can gate an external supply
        s_next.wakeOeN = (s_next.mode == swm_pkg::SWM_SLEEP);          // [RULE18]
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg             <= '0;
            s_reg.syncA       <= 28'hfc0_0000;
            s_reg.syncB       <= 28'hfc0_0000;
            s_reg.prev        <= 28'hfc0_0000;
            s_reg.mode        <= swm_pkg::SWM_NORMAL;
            s_reg.soOeN       <= 1'b1;
            s_reg.alertOeN    <= 1'b1;
            s_reg.polarity    <= `SWM_POL_RESET;
            s_reg.alertEnable <= `SWM_ENA_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Applied commands queue here for the user side; back-pressure holds pendValid
    swm_cmd_fifo #(
        .WIDTH (`SWM_WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .rst      (rst),
        .inValid  (s_reg.pendValid),
        .inReady  (fifoInReady),
        .inData   (s_reg.pendWord),
        .outValid (fifoOutValid),
        .outReady (cmdReady),
        .outData  (fifoOutData)
    );

    // Outputs from flip-flops; open-drain data lines always drive zero
    assign soOut      = s_reg.soOut;
    assign soOeN      = s_reg.soOeN;
    assign alertOut   = 1'b0;
    assign alertOeN   = s_reg.alertOeN;
    assign wakeOut    = 1'b0;
    assign wakeOeN    = s_reg.wakeOeN;
    assign cmdValid   = fifoOutValid;
    assign cmdWord    = fifoOutData;
    assign cmdDropped = s_reg.cmdDropped;

    property p_so_enable;
        @(posedge clk) disable iff (rst) csFall |=> !soOeN;
    endproperty
    a_so_enable: assert property (p_so_enable) else $error("output not enabled"); // [RULE1]

    property p_so_release;
        @(posedge clk) disable iff (rst) csRise |=> soOeN ##1 soOeN;
    endproperty
    a_so_release: assert property (p_so_release) else $error("output not released"); // [RULE2]

    property p_idle_tri;
        @(posedge clk) disable iff (rst) (csHigh && !csRise) |-> soOeN;
    endproperty
    a_idle_tri: assert property (p_idle_tri) else $error("output driven while idle"); // [RULE10]

    property p_alert_keep;
        @(posedge clk) disable iff (rst)
            (csRise && s_reg.changedDuringCs) |=> !alertOeN;
    endproperty
    a_alert_keep: assert property (p_alert_keep) else $error("alert lost"); // [RULE3]

    property p_alert_clear;
        @(posedge clk) disable iff (rst)
            (csRise && !s_reg.changedDuringCs && !anyChange) |=> alertOeN;
    endproperty
    a_alert_clear: assert property (p_alert_clear) else $error("alert not cleared"); // [RULE3]

    property p_alert_set;
        @(posedge clk) disable iff (rst) (anyChange && !isSleep) |=> !alertOeN;
    endproperty
    a_alert_set: assert property (p_alert_set) else $error("alert not raised"); // [RULE15]

    property p_rise_shift;
        @(posedge clk) disable iff (rst) sclkRise |=> soOut == $past(s_reg.shiftWord[23]);
    endproperty
    a_rise_shift: assert property (p_rise_shift) else $error("wrong output bit"); // [RULE8]

    property p_fall_sample;
        @(posedge clk) disable iff (rst)
            sclkFall |=> s_reg.shiftWord[0] == $past(s_reg.syncB[`SWM_PIN_SI]);
    endproperty
    a_fall_sample: assert property (p_fall_sample) else $error("input not sampled"); // [RULE7]

    property p_apply_settings;
        @(posedge clk) disable iff (rst)
            (csRise && wordDone && !isSleep && vddOk &&
             s_reg.shiftWord[23:16] == `SWM_CMD_SETTINGS)
            |=> s_reg.polarity == $past(s_reg.shiftWord[7:0]);
    endproperty
    a_apply_settings: assert property (p_apply_settings) else $error("settings not applied"); // [RULE4]

    property p_cs_wake;
        @(posedge clk) disable iff (rst) (csFall && isSleep && vddOk) |=> !wakeOeN;
    endproperty
    a_cs_wake: assert property (p_cs_wake) else $error("select did not wake"); // [RULE6]

    property p_wake_nosupply;
        @(posedge clk) disable iff (rst)
            (wakeFall && isSleep && !vddOk) |=> (s_reg.mode == swm_pkg::SWM_NORMAL) ##1 !wakeOeN;
    endproperty
    a_wake_nosupply: assert property (p_wake_nosupply) else $error("wake fall ignored"); // [RULE19]

    property p_alert_wake;
        @(posedge clk) disable iff (rst)
            (alertFall && isSleep && vddOk && s_reg.syncB[`SWM_PIN_WAKE]) |=> !wakeOeN;
    endproperty
    a_alert_wake: assert property (p_alert_wake) else $error("alert fall did not wake"); // [RULE17]
endmodule

// >>> dv/swm_host_model.sv
// Host controller model that masters the serial link of the switch monitor
`timescale 1ns/1ps
module swm_host_model (
    output logic     csN,
    output logic     sclk,
    output logic     si,
    input wire logic soLine
);
    localparam realtime HALF = 62.5;

    // Parked between frames: deselected, clock held low
    initial begin
        csN  = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end

    // One whole frame; select only moves while the clock is low
    task automatic xfer(input logic [47:0] tx, input int nBits, output logic [47:0] rx);
        rx  = '0;
        csN = 1'b0;
        // Data moves a quarter period after the fall, so it never races a sampled edge
        for (int i = nBits - 1; i >= 0; i--) begin
            #(HALF / 2) si = tx[i];
            #(HALF / 2) sclk = 1'b1;
            #HALF sclk = 1'b0;
            rx = {rx[46:0], soLine};
        end
        #(HALF / 2) csN = 1'b1;
        si  = ~si; // Released line must not keep showing the last bit
        #HALF;
    endtask
endmodule

// >>> dv/tb_top.sv
// Self-checking bench of the switch monitor serial slave and its command queue
`timescale 1ns/1ps
module tb_top;
    localparam int CEIL = 60000;
    logic        clk, rst, vddPresent, thermalFlag, cmdReady, extAlertLow, extWakeLow;
    logic        soOut, soOeN, alertOut, alertOeN, wakeOut, wakeOeN, cmdValid, cmdDropped;
    logic [7:0]  dualIn, pol;
    logic [13:0] gndIn;
    logic [23:0] cmdWord, st;
    logic [47:0] rx;
    wire logic   csN, sclk, si;
    int          miscompares, samplesChecked, cycles, drops;
    logic [23:0] got[$];

    // Wires: tri-state data out, pulled-up open-drain alert and wake
    wire logic soLine    = soOeN ? 1'bz : soOut;
    wire logic alertLine = ~((~alertOeN & ~alertOut) | extAlertLow);
    wire logic wakeLine  = ~((~wakeOeN & ~wakeOut) | extWakeLow);

    swm_serial_slave #(.FIFO_DEPTH(32)) swm_serial_slave_inst (
        .clk(clk), .rst(rst), .csN(csN), .sclk(sclk), .si(si), .soOut(soOut),
        .soOeN(soOeN), .alertIn(alertLine), .alertOut(alertOut), .alertOeN(alertOeN),
        .wakeIn(wakeLine), .wakeOut(wakeOut), .wakeOeN(wakeOeN),
        .vddPresent(vddPresent), .thermalFlag(thermalFlag),
        .dual_polarity_inputs(dualIn), .ground_contact_inputs(gndIn),
        .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWord(cmdWord),
        .cmdDropped(cmdDropped));
    swm_host_model swm_host_model_inst (.csN(csN), .sclk(sclk), .si(si), .soLine(soLine));

    always #2.5 clk = ~clk;

    // Collect queued words and drop pulses; cut a hang short
    always @(posedge clk) begin
        if (cmdValid === 1'b1 && cmdReady === 1'b1)
            got.push_back(cmdWord);
        if (cmdDropped === 1'b1)
            drops++;
        cycles++;
        if (cycles == CEIL) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
        samplesChecked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", samplesChecked, miscompares);
        if (miscompares == 0 && samplesChecked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic waitCycles(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Expected status: closed reads as one, whatever the contact type
    function automatic logic [23:0] expSt(input logic a);
        return {thermalFlag, a, ~gndIn, ~(dualIn ^ pol)};
    endfunction

    // One 24-bit frame, then the applied word must reach the queue
    task automatic run(input logic [23:0] cmd);
        int n0;
        n0 = got.size();
        check(soOeN, 1'b1, "idle output");
        swm_host_model_inst.xfer({24'h00_0000, cmd}, 24, rx);
        waitCycles(4);
        st = rx[23:0];
        check(soOeN, 1'b1, "output released");
        check(got.size(), n0 + 1, "queued");
        check(got[$], cmd, "applied word");
    endtask

    task automatic test_status();
        check(alertOeN, 1'b0, "alert after change");
        check(wakeOeN, 1'b0, "normal wake pin");
        check(alertOut, 1'b0, "alert data low");
        check(wakeOut, 1'b0, "wake data low");
        run(24'h00_1234);
        check(st, expSt(1'b1), "status word");
        check(alertOeN, 1'b1, "alert cleared");
        $display("test status done");
    endtask

    // A switch moves in mid-frame: the alert must survive the select rise
    task automatic test_alert_hold();
        fork
            run(24'h00_0000);
            begin
                #1000;
                @(negedge clk);
                gndIn[0] = ~gndIn[0];
            end
        join
        check(st[22], 1'b0, "no alert latched");
        check(alertOeN, 1'b0, "alert kept");
        run(24'h00_0000);
        check(st, expSt(1'b1), "alert reported");
        check(alertOeN, 1'b1, "alert released");
        $display("test alert hold done");
    endtask

    // Short frame is thrown away; a double frame passes input through
    task automatic test_words();
        int n0;
        n0 = got.size();
        swm_host_model_inst.xfer(48'h0000_0000_0000, 23, rx);
        waitCycles(10);
        check(got.size(), n0, "partial word");
        swm_host_model_inst.xfer(48'h0000_AA00_0055, 48, rx);
        waitCycles(10);
        check(rx[23:0], 24'h00_00AA, "chained data");
        check(rx[47:24], expSt(1'b0), "chained status");
        check(got[$], 24'h00_0055, "last word applied");
        $display("test words done");
    endtask

    task automatic test_config();
        run(24'h02_0000);
        gndIn[1] = ~gndIn[1];
        waitCycles(20);
        check(alertOeN, 1'b1, "disabled input quiet");
        run(24'h01_000F);
        pol = 8'h0F;
        thermalFlag = 1'b0; // Thermal bit must follow its input, not stay high
        run(24'h00_0000);
        check(st, expSt(1'b0), "polarity status");
        $display("test config done");
    endtask

    task automatic test_sleep();
        run(24'h03_0000);
        check(wakeOeN, 1'b1, "sleep releases wake");
        run(24'h00_0000); // Status of a waking frame is not trusted
        check(wakeOeN, 1'b0, "select fall wakes");
        run(24'h03_0000);
        extWakeLow = 1'b1;
        waitCycles(10);
        check(wakeOeN, 1'b0, "wake pin fall");
        extWakeLow = 1'b0;
        run(24'h03_0000);
        extAlertLow = 1'b1;
        waitCycles(10);
        check(wakeOeN, 1'b0, "alert line fall");
        extAlertLow = 1'b0;
        run(24'h03_0000);
        vddPresent = 1'b0;
        extAlertLow = 1'b1;
        waitCycles(10);
        check(wakeOeN, 1'b1, "no supply, alert ignored");
        extWakeLow = 1'b1;
        waitCycles(10);
        check(wakeOeN, 1'b0, "wake without supply");
        vddPresent = 1'b1;
        extAlertLow = 1'b0;
        extWakeLow = 1'b0;
        $display("test sleep done");
    endtask

    // Queue holds 32 plus slot plus output register; the next word is dropped
    task automatic test_fifo();
        cmdReady = 1'b0;
        drops = 0;
        got.delete();
        for (int i = 0; i < 35; i++)
            swm_host_model_inst.xfer({24'h00_0000, 16'h4000, 8'(i)}, 24, rx);
        waitCycles(10);
        check(drops, 1, "overflow dropped");
        for (int i = 0; i < 200; i++) begin
            @(negedge clk);
            cmdReady = i[0];
        end
        check(cmdValid, 1'b0, "drained");
        check(got.size(), 34, "drained count");
        for (int i = 0; i < 34; i++)
            check(got[i], {16'h4000, 8'(i)}, "drain order");
        cmdReady = 1'b1;
        $display("test fifo done");
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        vddPresent = 1'b1;
        thermalFlag = 1'b1;
        cmdReady = 1'b1;
        extAlertLow = 1'b0;
        extWakeLow = 1'b0;
        pol = 8'hFF;
        dualIn = 8'hA5;
        gndIn = 14'h3C3A;
        miscompares = 0;
        samplesChecked = 0;
        cycles = 0;
        drops = 0;
        waitCycles(11); // Eleven rising edges see reset high
        rst = 1'b0;
        waitCycles(20);
        test_status();
        test_alert_hold();
        test_words();
        test_config();
        test_sleep();
        test_fifo();
        give_verdict();
    end
endmodule
